// ---- hw/swc_pkg.sv ----
// Standby controller package: register map, fields and mode codes.
// Assumes a single 40 MHz core clock and the plain strobe register port.
package swc_pkg;

    // Register offsets (byte address on the plain port).
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h01;
    localparam logic [7:0] ADDR_IRQCFG_A = 8'h02;
    localparam logic [7:0] ADDR_IRQCFG_B = 8'h03;
    localparam logic [7:0] ADDR_IRQEN    = 8'h04;
    localparam logic [7:0] ADDR_P0_DATA  = 8'h05;
    localparam logic [7:0] ADDR_P0_CFG   = 8'h06;
    localparam logic [7:0] ADDR_P0_IEN   = 8'h07;
    localparam logic [7:0] ADDR_PX_DIR   = 8'h08;
    localparam logic [7:0] ADDR_PX_OUT   = 8'h09;
    localparam logic [7:0] ADDR_PX_PIN   = 8'h0A;
    localparam logic [7:0] ADDR_PEND     = 8'h0B;

    // Control register fields.
    localparam int CTRL_HOLD     = 0;
    localparam int CTRL_XHOLD    = 1;
    localparam int CTRL_CER_EN   = 2;
    localparam int CTRL_XTAL_EN  = 3;
    localparam int CTRL_MED_EN   = 4;
    localparam int CTRL_MRC_EN   = 5;
    localparam int CTRL_XTAL_SEL = 6;

    // Reset values.
    localparam logic [7:0] CTRL_RST   = 8'h30;
    localparam logic [7:0] ZERO8      = 8'h00;

    // Detection mode codes per external interrupt.
    localparam logic [2:0] DET_RISE  = 3'h0;
    localparam logic [2:0] DET_FALL  = 3'h1;
    localparam logic [2:0] DET_BOTH  = 3'h2;
    localparam logic [2:0] DET_HIGH  = 3'h3;
    localparam logic [2:0] DET_LOW   = 3'h4;

    // Number of external interrupt lines and internal reset pulse length.
    localparam int NUM_EXT       = 6;
    localparam int RST_OUT_NS    = 500;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_OUT_CYC   = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power modes.
    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_HOLD,
        SWC_XHOLD
    } swc_mode_t;

endpackage : swc_pkg

// ---- hw/swc_irq_det.sv ----
// One external interrupt detector, edge or level sense.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module swc_irq_det #(
    parameter bit LEVEL_OK = 1'b0,
    parameter bit BOTH_OK  = 1'b1
) (
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Configuration and pin.
    input  wire logic [2:0] i_mode,
    input  wire logic       i_pin,
    input  wire logic       i_clr,
    // Results.
    output logic            o_pend,
    output logic            o_level
);

    logic prev_r, prev_nxt;
    logic pend_r, pend_nxt;
    logic hit;

    // Detection; unsupported modes never fire.
    always_comb begin
        hit = 1'b0;
        o_level = 1'b0;
        case (i_mode)
            swc_pkg::DET_RISE: hit = i_pin & ~prev_r;
            swc_pkg::DET_FALL: hit = ~i_pin & prev_r;
            swc_pkg::DET_BOTH: hit = BOTH_OK & (i_pin ^ prev_r);
            swc_pkg::DET_HIGH: begin
                hit     = LEVEL_OK & i_pin;
                o_level = LEVEL_OK;
            end
            swc_pkg::DET_LOW: begin
                hit     = LEVEL_OK & ~i_pin;
                o_level = LEVEL_OK;
            end
            default: hit = 1'b0;
        endcase
        prev_nxt = i_pin;
        // Set wins over clear.
        pend_nxt = hit | (pend_r & ~i_clr);
    end

    // State registers.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prev_r <= i_pin; // No false edge after reset.
            pend_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign o_pend = pend_r;

endmodule : swc_irq_det
`default_nettype wire

// ---- hw/swc_top.sv ----
// Standby and wake-up controller: hold and crystal hold modes, oscillator gating,
// wake detection from reset sources, external interrupts and port zero, port I/O.
// Assumes synchronous pins, one 40 MHz clock and a plain strobe register port.
`timescale 1ns/1ps
`default_nettype none

module swc_top #(
    parameter int PX_W      = 16,
    parameter int FILT_LEN  = 4
) (
    // Clock and reset.
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // Register port.
    input  wire logic [7:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    // Reset sources and reset pin.
    input  wire logic              i_reset_pin_n,
    output logic                   o_reset_pin_n_o,
    output logic                   o_reset_pin_oe,
    input  wire logic              i_lvd_rst,
    input  wire logic              i_wdt_rst,
    input  wire logic              i_wdt_slow_rc_run,
    input  wire logic              i_base_timer_irq,
    // External interrupt pins.
    input  wire logic              i_ext_irq_zero,
    input  wire logic              i_ext_irq_one,
    input  wire logic              i_ext_irq_two,
    input  wire logic              i_filtered_irq_pin,
    input  wire logic              i_ext_irq_four,
    input  wire logic              i_ext_irq_five,
    // Port zero.
    input  wire logic [7:0]        i_port_zero,
    output logic      [7:0]        o_port_zero,
    output logic      [7:0]        o_port_zero_oe,
    output logic      [1:0]        o_port_zero_pu,
    // Ports one, two, three and seven packed together.
    input  wire logic [PX_W-1:0]   i_port_x,
    output logic      [PX_W-1:0]   o_port_x,
    output logic      [PX_W-1:0]   o_port_x_oe,
    // System gating.
    output logic                   o_cpu_run,
    output logic                   o_periph_run,
    output logic                   o_base_timer_run,
    output logic                   o_ceramic_osc_en,
    output logic                   o_xtal_osc_en,
    output logic                   o_med_rc_osc_en,
    output logic                   o_multi_freq_rc_osc_en,
    output logic                   o_slow_rc_osc_en,
    output logic      [5:0]        o_irq_pend,
    output logic                   o_port_zero_irq,
    output logic                   o_timer_evt,
    output logic                   o_timer_cap
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]      ctrl_r, ctrl_nxt;
    logic [7:0]      cfg_a_r, cfg_a_nxt;
    logic [7:0]      cfg_b_r, cfg_b_nxt;
    logic [7:0]      irqen_r, irqen_nxt;
    logic [7:0]      p0_out_r, p0_out_nxt;
    logic [7:0]      p0_cfg_r, p0_cfg_nxt;
    logic [7:0]      p0_ien_r, p0_ien_nxt;
    logic [PX_W-1:0] px_dir_r, px_dir_nxt;
    logic [PX_W-1:0] px_out_r, px_out_nxt;
    logic [7:0]      rdata_r, rdata_nxt;
    logic [7:0]      p0_prev_r, p0_prev_nxt;
    logic            p0_pend_r, p0_pend_nxt;
    logic [FILT_LEN-1:0] filt_r, filt_nxt;
    logic            filt_lvl_r, filt_lvl_nxt;
    logic [7:0]      rst_cnt_r, rst_cnt_nxt;
    swc_pkg::swc_mode_t mode_r, mode_nxt;

    // Per-line detection.
    logic [5:0] pins;
    logic [5:0] pend;
    logic [5:0] lvl;
    logic [5:0] clr;
    logic [2:0] modes [0:5];
    logic       ext_wake;
    logic       rst_wake;
    logic       wake;
    logic       int_rst;

    assign pins = {i_ext_irq_five, i_ext_irq_four, filt_lvl_r,
                   i_ext_irq_two, i_ext_irq_one, i_ext_irq_zero};

    // Mode fields: cfg_a holds lines zero/one, cfg_b lines two to five as 2-bit codes.
    assign modes[0] = cfg_a_r[2:0];
    assign modes[1] = cfg_a_r[6:4];
    assign modes[2] = {1'b0, cfg_b_r[1:0]};
    assign modes[3] = {1'b0, cfg_b_r[3:2]};
    assign modes[4] = {1'b0, cfg_b_r[5:4]};
    assign modes[5] = {1'b0, cfg_b_r[7:6]};

    // Writing one to a pending bit clears it.
    assign clr = (i_wr && i_addr == swc_pkg::ADDR_PEND) ? i_wdata[5:0] : 6'h00;

    // ------------------------------------------------------------
    // Interrupt detectors
    // ------------------------------------------------------------
    // detection capability
    genvar g;
    generate
        for (g = 0; g < swc_pkg::NUM_EXT; g++) begin : g_det
            swc_irq_det #(
                .LEVEL_OK (g < 2),
                .BOTH_OK  (g >= 2)
            ) u_det (
                .i_core_clk (i_core_clk),
                .i_rst      (i_rst),
                .i_mode     (modes[g]),
                .i_pin      (pins[g]),
                .i_clr      (clr[g]),
                .o_pend     (pend[g]),
                .o_level    (lvl[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Wake and reset logic
    // ------------------------------------------------------------
    // pin wake sources
    assign ext_wake = |(pend & irqen_r[5:0] & {2'b11, 1'b0, 1'b1, lvl[1], lvl[0]})
                    | (p0_pend_r & |p0_ien_r);
    assign rst_wake = ~i_reset_pin_n | i_lvd_rst | i_wdt_rst;
    assign wake     = ext_wake | (mode_r == swc_pkg::SWC_XHOLD && i_base_timer_irq);
    assign int_rst  = i_lvd_rst | i_wdt_rst;

    // Mode machine and register writes.
    always_comb begin
        mode_nxt   = mode_r;
        ctrl_nxt   = ctrl_r;
        cfg_a_nxt  = cfg_a_r;
        cfg_b_nxt  = cfg_b_r;
        irqen_nxt  = irqen_r;
        p0_out_nxt = p0_out_r;
        p0_cfg_nxt = p0_cfg_r;
        p0_ien_nxt = p0_ien_r;
        px_dir_nxt = px_dir_r;
        px_out_nxt = px_out_r;
        rst_cnt_nxt = (rst_cnt_r != 8'h00) ? rst_cnt_r - 8'h01 : 8'h00;
        if (int_rst) begin
            rst_cnt_nxt = 8'(swc_pkg::RST_OUT_CYC);
        end
        if (i_wr) begin
            case (i_addr)
                swc_pkg::ADDR_CTRL:     ctrl_nxt   = i_wdata;
                swc_pkg::ADDR_IRQCFG_A: cfg_a_nxt  = i_wdata;
                swc_pkg::ADDR_IRQCFG_B: cfg_b_nxt  = i_wdata;
                swc_pkg::ADDR_IRQEN:    irqen_nxt  = i_wdata;
                swc_pkg::ADDR_P0_DATA:  p0_out_nxt = i_wdata;
                swc_pkg::ADDR_P0_CFG:   p0_cfg_nxt = i_wdata;
                swc_pkg::ADDR_P0_IEN:   p0_ien_nxt = i_wdata;
                swc_pkg::ADDR_PX_DIR:   px_dir_nxt = {(PX_W/8){i_wdata}};
                swc_pkg::ADDR_PX_OUT:   px_out_nxt = {(PX_W/8){i_wdata}};
                default: ;
            endcase
        end
        case (mode_r)
            swc_pkg::SWC_RUN: begin
                if (i_wr && i_addr == swc_pkg::ADDR_CTRL && !rst_wake) begin
                    if (i_wdata[swc_pkg::CTRL_XHOLD] && ctrl_r[swc_pkg::CTRL_XTAL_SEL]) begin
                        mode_nxt = swc_pkg::SWC_XHOLD;
                    end else if (i_wdata[swc_pkg::CTRL_HOLD]) begin
                        mode_nxt = swc_pkg::SWC_HOLD;
                    end
                end
                ctrl_nxt[swc_pkg::CTRL_HOLD]  = 1'b0;
                ctrl_nxt[swc_pkg::CTRL_XHOLD] = 1'b0;
            end
            swc_pkg::SWC_HOLD, swc_pkg::SWC_XHOLD: begin
                if (rst_wake || wake) begin
                    mode_nxt = swc_pkg::SWC_RUN;
                end
            end
            default: mode_nxt = swc_pkg::SWC_RUN;
        endcase
    end

    // Port zero change detect, set wins, and read data.
    always_comb begin
        p0_prev_nxt = i_port_zero;
        p0_pend_nxt = (|((i_port_zero ^ p0_prev_r) & p0_ien_r))
                    | (p0_pend_r & ~(i_wr && i_addr == swc_pkg::ADDR_PEND && i_wdata[7]));
        filt_nxt     = {filt_r[FILT_LEN-2:0], i_filtered_irq_pin};
        filt_lvl_nxt = filt_lvl_r;
        if (&filt_r) begin
            filt_lvl_nxt = 1'b1;
        end else if (~|filt_r) begin
            filt_lvl_nxt = 1'b0;
        end
        rdata_nxt = swc_pkg::ZERO8;
        if (i_rd) begin
            case (i_addr)
                swc_pkg::ADDR_CTRL:     rdata_nxt = ctrl_r;
                swc_pkg::ADDR_STATUS:   rdata_nxt = {6'h00, mode_r};
                swc_pkg::ADDR_IRQCFG_A: rdata_nxt = cfg_a_r;
                swc_pkg::ADDR_IRQCFG_B: rdata_nxt = cfg_b_r;
                swc_pkg::ADDR_IRQEN:    rdata_nxt = irqen_r;
                swc_pkg::ADDR_P0_DATA:  rdata_nxt = i_port_zero;
                swc_pkg::ADDR_P0_CFG:   rdata_nxt = p0_cfg_r;
                swc_pkg::ADDR_P0_IEN:   rdata_nxt = p0_ien_r;
                swc_pkg::ADDR_PX_DIR:   rdata_nxt = px_dir_r[7:0];
                swc_pkg::ADDR_PX_PIN:   rdata_nxt = i_port_x[7:0];
                swc_pkg::ADDR_PEND:     rdata_nxt = {p0_pend_r, 1'b0, pend};
                default:                rdata_nxt = swc_pkg::ZERO8;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // ceramic and crystal oscillators off at reset, medium and multi-frequency RC on
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_r     <= swc_pkg::SWC_RUN;
            ctrl_r     <= swc_pkg::CTRL_RST;
            cfg_a_r    <= swc_pkg::ZERO8;
            cfg_b_r    <= swc_pkg::ZERO8;
            irqen_r    <= swc_pkg::ZERO8;
            p0_out_r   <= swc_pkg::ZERO8;
            p0_cfg_r   <= swc_pkg::ZERO8;
            p0_ien_r   <= swc_pkg::ZERO8;
            px_dir_r   <= '0;
            px_out_r   <= '0;
            rdata_r    <= swc_pkg::ZERO8;
            p0_prev_r  <= i_port_zero;
            p0_pend_r  <= 1'b0;
            filt_r     <= '0;
            filt_lvl_r <= 1'b0;
            rst_cnt_r  <= swc_pkg::ZERO8;
        end else begin
            mode_r     <= mode_nxt;
            ctrl_r     <= ctrl_nxt;
            cfg_a_r    <= cfg_a_nxt;
            cfg_b_r    <= cfg_b_nxt;
            irqen_r    <= irqen_nxt;
            p0_out_r   <= p0_out_nxt;
            p0_cfg_r   <= p0_cfg_nxt;
            p0_ien_r   <= p0_ien_nxt;
            px_dir_r   <= px_dir_nxt;
            px_out_r   <= px_out_nxt;
            rdata_r    <= rdata_nxt;
            p0_prev_r  <= p0_prev_nxt;
            p0_pend_r  <= p0_pend_nxt;
            filt_r     <= filt_nxt;
            filt_lvl_r <= filt_lvl_nxt;
            rst_cnt_r  <= rst_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // execution and peripheral gating
    assign o_cpu_run        = (mode_r == swc_pkg::SWC_RUN);
    assign o_periph_run     = (mode_r == swc_pkg::SWC_RUN);
    assign o_base_timer_run = (mode_r != swc_pkg::SWC_HOLD);
    assign o_ceramic_osc_en       = ctrl_r[swc_pkg::CTRL_CER_EN] && mode_r == swc_pkg::SWC_RUN;
    assign o_xtal_osc_en          = ctrl_r[swc_pkg::CTRL_XTAL_EN] && mode_r != swc_pkg::SWC_HOLD;
    assign o_med_rc_osc_en        = ctrl_r[swc_pkg::CTRL_MED_EN] && mode_r == swc_pkg::SWC_RUN;
    assign o_multi_freq_rc_osc_en = ctrl_r[swc_pkg::CTRL_MRC_EN] && mode_r == swc_pkg::SWC_RUN;
    assign o_slow_rc_osc_en = i_wdt_slow_rc_run;
    // reset pin driven low for internal reset
    assign o_reset_pin_n_o = 1'b0;
    assign o_reset_pin_oe  = (rst_cnt_r != 8'h00);
    assign o_port_zero    = p0_out_r;
    assign o_port_zero_oe = {{4{p0_cfg_r[1]}}, {4{p0_cfg_r[0]}}};
    assign o_port_zero_pu = p0_cfg_r[5:4];
    assign o_port_x    = px_out_r;
    assign o_port_x_oe = px_dir_r;
    assign o_irq_pend      = pend;
    assign o_port_zero_irq = p0_pend_r;
    // timer inputs from lines four and five
    assign o_timer_evt = i_ext_irq_four | i_ext_irq_five;
    assign o_timer_cap = i_ext_irq_four | i_ext_irq_five;
    assign o_rdata     = rdata_r;

endmodule : swc_top
`default_nettype wire

// ---- testbench/swc_properties.sv ----
// Checker for the standby controller.
// Assumes a bind into swc_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module swc_properties (
    // Clock and reset.
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    // Watched inputs.
    input wire logic       i_reset_pin_n,
    input wire logic       i_lvd_rst,
    input wire logic       i_wdt_rst,
    input wire logic       i_wdt_slow_rc_run,
    input wire logic       i_base_timer_irq,
    input wire logic       i_ext_irq_four,
    input wire logic       i_ext_irq_five,
    // Watched outputs.
    input wire logic       o_reset_pin_n_o,
    input wire logic       o_reset_pin_oe,
    input wire logic [7:0] o_port_zero_oe,
    input wire logic       o_cpu_run,
    input wire logic       o_periph_run,
    input wire logic       o_base_timer_run,
    input wire logic       o_ceramic_osc_en,
    input wire logic       o_xtal_osc_en,
    input wire logic       o_med_rc_osc_en,
    input wire logic       o_multi_freq_rc_osc_en,
    input wire logic       o_slow_rc_osc_en,
    input wire logic       o_timer_evt,
    input wire logic       o_timer_cap
);
    // --------------------------------------------------------------
    // Mode decode
    // --------------------------------------------------------------
    // Hold is the only mode that stops the base timer.
    logic hold_w;
    logic xhold_w;
    logic int_rst;
    assign hold_w  = !o_base_timer_run;
    assign xhold_w = !o_cpu_run && o_base_timer_run;
    assign int_rst = i_lvd_rst || i_wdt_rst;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_hold_freeze: assert property (hold_w |-> !o_cpu_run && !o_periph_run)
        else $error("core runs in hold");
    a_hold_osc_off: assert property (hold_w |-> !o_ceramic_osc_en && !o_xtal_osc_en
        && !o_med_rc_osc_en && !o_multi_freq_rc_osc_en)
        else $error("oscillator runs in hold");
    a_slow_rc_wdt: assert property ($stable(i_wdt_slow_rc_run)
        |-> o_slow_rc_osc_en == i_wdt_slow_rc_run)
        else $error("slow RC not following watchdog");
    a_reset_wakes: assert property (!o_cpu_run && (!i_reset_pin_n || int_rst)
        |-> ##[1:3] o_cpu_run)
        else $error("reset did not wake");
    a_xhold_stop: assert property (xhold_w |-> !o_periph_run && !o_ceramic_osc_en
        && !o_med_rc_osc_en && !o_multi_freq_rc_osc_en)
        else $error("part runs in crystal hold");
    a_xtal_kept: assert property ($fell(o_cpu_run) && o_base_timer_run
        |-> o_xtal_osc_en == $past(o_xtal_osc_en))
        else $error("crystal changed on entry");
    a_base_wake: assert property (xhold_w && i_base_timer_irq |-> ##[1:2] o_cpu_run)
        else $error("base timer did not wake");
    a_timer_inputs: assert property (o_timer_evt == (i_ext_irq_four || i_ext_irq_five)
        && o_timer_cap == o_timer_evt)
        else $error("timer inputs wrong");
    a_p0_nibble: assert property ((o_port_zero_oe[3:0] == 4'h0 || o_port_zero_oe[3:0] == 4'hF)
        && (o_port_zero_oe[7:4] == 4'h0 || o_port_zero_oe[7:4] == 4'hF))
        else $error("nibble direction split");
    a_rst_pin_low: assert property (o_reset_pin_oe |-> !o_reset_pin_n_o)
        else $error("reset pin driven high");
    a_rst_pin_hold: assert property ($fell(int_rst) |=> o_reset_pin_oe [*8])
        else $error("reset pin drive too short");
    a_osc_after_rst: assert property ($past(i_rst) |-> !o_ceramic_osc_en && !o_xtal_osc_en)
        else $error("oscillator on after reset");

    // Main scenarios reached.
    c_hold: cover property ($rose(hold_w));
    c_xhold: cover property ($rose(xhold_w));
    c_rst_drive: cover property ($rose(o_reset_pin_oe));
endmodule : swc_properties

bind swc_top swc_properties u_props (.*);
`default_nettype wire

// ---- testbench/swc_pin_src.sv ----
// Model of the external pins: wake sources, reset pin and port levels.
// Assumes the bench drives activity and polarity vectors.
`timescale 1ns/1ps
`default_nettype none
module swc_pin_src (
    // Commands from the bench.
    input  wire logic [10:0] i_act,
    input  wire logic [5:0]  i_pol,
    input  wire logic [15:0] i_px_ext,
    // Drivers from the controller.
    input  wire logic        i_rst_oe,
    input  wire logic        i_rst_o,
    input  wire logic [7:0]  i_p0_out,
    input  wire logic [7:0]  i_p0_oe,
    input  wire logic [15:0] i_px_out,
    input  wire logic [15:0] i_px_oe,
    // Levels seen by the controller.
    output logic      [5:0]  o_ext,
    output logic             o_rst_n,
    output logic             o_lvd,
    output logic             o_wdt,
    output logic             o_base,
    output logic      [7:0]  o_p0,
    output logic      [15:0] o_px
);
    // Interrupt lines idle at their polarity level and flip when active.
    assign o_ext  = i_act[5:0] ^ i_pol;
    assign o_lvd  = i_act[7];
    assign o_wdt  = i_act[8];
    assign o_base = i_act[10];
    assign o_rst_n = !(i_rst_oe && !i_rst_o) && !i_act[6];
    assign o_p0 = (i_p0_oe & i_p0_out) | (~i_p0_oe & {8{i_act[9]}});
    assign o_px = (i_px_oe & i_px_out) | (~i_px_oe & i_px_ext);
endmodule : swc_pin_src
`default_nettype wire

// ---- testbench/swc_top_bench.sv ----
// Self-checking bench for the standby controller.
// Assumes the package, design, checker and pin model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module swc_top_bench;
    logic        i_core_clk, i_rst, i_wr, i_rd, i_wdt_slow_rc_run, rd_d;
    logic [7:0]  i_addr, i_wdata, o_rdata, i_port_zero, o_port_zero, o_port_zero_oe, e_v, r, d;
    logic [15:0] i_port_x, o_port_x, o_port_x_oe, px_ext;
    logic [1:0]  o_port_zero_pu;
    logic [5:0]  ext, pol, o_irq_pend;
    logic [10:0] act;
    logic        rst_n, rst_no, rst_oe, lvd, wdt, base, o_cpu_run, per, btr, cer, xt, med;
    logic        multi_freq_rc_osc, src, p0i, tev, tcp;
    logic [7:0]  exp_q[$];
    int          fails = 0;
    int          tests_run = 0;
    int          seed = 32'hd9ca022c;

    swc_top u_dut (
        .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_reset_pin_n(rst_n),
        .o_reset_pin_n_o(rst_no), .o_reset_pin_oe(rst_oe), .i_lvd_rst(lvd), .i_wdt_rst(wdt),
        .i_wdt_slow_rc_run, .i_base_timer_irq(base),
        .i_ext_irq_zero(ext[0]), .i_ext_irq_one(ext[1]), .i_ext_irq_two(ext[2]),
        .i_filtered_irq_pin(ext[3]), .i_ext_irq_four(ext[4]), .i_ext_irq_five(ext[5]),
        .i_port_zero, .o_port_zero, .o_port_zero_oe, .o_port_zero_pu, .i_port_x, .o_port_x,
        .o_port_x_oe, .o_cpu_run, .o_periph_run(per),
        .o_base_timer_run(btr), .o_ceramic_osc_en(cer), .o_xtal_osc_en(xt),
        .o_med_rc_osc_en(med), .o_multi_freq_rc_osc_en(multi_freq_rc_osc), .o_slow_rc_osc_en(src),
        .o_irq_pend, .o_port_zero_irq(p0i), .o_timer_evt(tev), .o_timer_cap(tcp));

    swc_pin_src u_src (
        .i_act(act), .i_pol(pol), .i_px_ext(px_ext), .i_rst_oe(rst_oe), .i_rst_o(rst_no),
        .i_p0_out(o_port_zero), .i_p0_oe(o_port_zero_oe), .i_px_out(o_port_x),
        .i_px_oe(o_port_x_oe), .o_ext(ext), .o_rst_n(rst_n), .o_lvd(lvd), .o_wdt(wdt),
        .o_base(base), .o_p0(i_port_zero), .o_px(i_port_x));

    // 40 MHz core clock.
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    // --------------------------------------------------------------
    // Register port tasks
    // --------------------------------------------------------------
    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // One-cycle read; expected value queued.
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
    endtask : rd

    // Read data stand one cycle after the strobe.
    always @(posedge i_core_clk) begin
        if (rd_d && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK(o_rdata, e_v)
        end
        rd_d <= i_rd;
    end

    // Enter standby, fire a source, check the wake.
    task automatic try_wake(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b,
                            input logic [7:0] en, input logic [5:0] pl,
                            input logic [10:0] ac, input logic w);
        int n;
        pol <= pl;
        i_wdt_slow_rc_run <= 1'($random(seed));
        wr(swc_pkg::ADDR_IRQCFG_A, a);
        wr(swc_pkg::ADDR_IRQCFG_B, b);
        wr(swc_pkg::ADDR_IRQEN, en);
        wr(swc_pkg::ADDR_PEND, 8'hFF);
        wr(swc_pkg::ADDR_CTRL, c & 8'hFC);
        wr(swc_pkg::ADDR_CTRL, c);
        repeat (2) @(posedge i_core_clk);
        `CHK(o_cpu_run, 1'b0)
        rd(swc_pkg::ADDR_STATUS, c[1] ? 8'h02 : 8'h01);
        act <= ac;
        n = 0;
        while (o_cpu_run !== 1'b1 && n < 40) begin
            @(posedge i_core_clk);
            n++;
        end
        `CHK(o_cpu_run, w)
        `CHK(o_irq_pend & en[5:0], ac[5:0])
        // Pull the reset pin to end any standby.
        act <= 11'h040;
        repeat (4) @(posedge i_core_clk);
        act <= 11'h000;
        repeat (30) @(posedge i_core_clk);
    endtask : try_wake

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wdt_slow_rc_run = 1'b0;
        act = 11'h000;
        pol = 6'h00;
        px_ext = 16'h0000;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(swc_pkg::ADDR_CTRL, swc_pkg::CTRL_RST);
        rd(swc_pkg::ADDR_STATUS, 8'h00);
        rd(8'hFF, 8'h00);
        wr(swc_pkg::ADDR_P0_IEN, 8'hFF);
        // Lines in each detection mode, reset sources, port zero.
        try_wake(8'h3D, 8'h03, 8'h00, 8'h01, 6'h00, 11'h001, 1'b1);
        try_wake(8'h3D, 8'h40, 8'h00, 8'h02, 6'h02, 11'h002, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h01, 6'h00, 11'h001, 1'b0);
        try_wake(8'h3D, 8'h10, 8'h00, 8'h02, 6'h02, 11'h002, 1'b0);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h04, 6'h00, 11'h004, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h01, 8'h04, 6'h04, 11'h004, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h20, 8'h10, 6'h00, 11'h010, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h20, 6'h00, 11'h020, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h08, 6'h00, 11'h008, 1'b0);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h00, 6'h00, 11'h040, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h00, 6'h00, 11'h080, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h00, 6'h00, 11'h100, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h00, 6'h00, 11'h200, 1'b1);
        try_wake(8'h3D, 8'h00, 8'h00, 8'h00, 6'h00, 11'h400, 1'b0);
        // Crystal hold refused until the crystal is selected.
        wr(swc_pkg::ADDR_CTRL, 8'h38);
        wr(swc_pkg::ADDR_CTRL, 8'h3A);
        repeat (2) @(posedge i_core_clk);
        `CHK(o_cpu_run, 1'b1)
        try_wake(8'h4A, 8'h00, 8'h00, 8'h00, 6'h00, 11'h400, 1'b1);
        try_wake(8'h4A, 8'h00, 8'h00, 8'h04, 6'h00, 11'h004, 1'b1);
        // Port directions and pin read-back.
        r = 8'($random(seed));
        d = 8'($random(seed));
        px_ext <= 16'($random(seed));
        wr(swc_pkg::ADDR_PX_DIR, r);
        wr(swc_pkg::ADDR_PX_OUT, d);
        @(posedge i_core_clk);
        `CHK(o_port_x_oe, {r, r})
        rd(swc_pkg::ADDR_PX_PIN, (r & d) | (~r & px_ext[7:0]));
        wr(swc_pkg::ADDR_P0_CFG, 8'h21);
        wr(swc_pkg::ADDR_P0_DATA, d);
        @(posedge i_core_clk);
        `CHK(o_port_zero_oe, 8'h0F)
        `CHK(o_port_zero_pu, 2'b10)
        rd(swc_pkg::ADDR_P0_DATA, {4'h0, d[3:0]});
        repeat (3) @(posedge i_core_clk);
        give_verdict();
    end

    // Watchdog well past the expected run length.
    initial begin
        repeat (20000) @(posedge i_core_clk);
        fails++;
        give_verdict();
    end
endmodule : swc_top_bench
`default_nettype wire
